// ---- logic/cfm_pkg.sv ----
package cfm_pkg;

    // timing
    localparam int CLK_MHZ = 20;
    localparam int TX_TIMEOUT_US = 1200;
    localparam int TX_TIMEOUT_CYC = TX_TIMEOUT_US * CLK_MHZ;
    localparam int RESUME_US = 200;
    localparam int RESUME_CYC = RESUME_US * CLK_MHZ;
    localparam int BUS_DOM_CYC_DEF = 2000;
    localparam int UV_FILTER_CYC_DEF = 2000;

    // register map
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
    localparam int CTRL_MODE_LSB = 0;
    localparam int MODE_W = 3;
    localparam int ST_BUS_DOM = 0;
    localparam int ST_CLAMPED = 1;
    localparam int ST_TX_TIMEOUT = 2;
    localparam int ST_THERMAL = 3;
    localparam int ST_DRV_EN = 4;
    localparam int ST_FAULT_N = 5;
    localparam int ST_CAN_OFF = 6;
    localparam int ST_LOAD_OFF = 7;
    localparam int ST_MODE_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [MODE_W-1:0] {
        CFM_NORMAL,
        CFM_SILENT,
        CFM_STANDBY,
        CFM_GOTOSLEEP,
        CFM_SLEEP
    } cfm_mode_t;

    // low-power mode after reset, as the floating pins select
    localparam cfm_mode_t MODE_RESET = CFM_SLEEP;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } cfm_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cfm_axi_rsp_t;

endpackage

// ---- logic/cfm_fault_monitor.sv ----
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
// Contract
// - set bus-stuck flag when bus stays dominant past the bus dominant time
// - bus-stuck flag drives fault output low on normal-to-silent change
// - clear bus-stuck flag on receive rising edge or entering most modes
// - detect local faults in normal and silent, report on normal-to-silent
// - every other mode change clears the local fault indications
// - transmit low before driver activation keeps driver off
// - clamped fault clears on normal entry, recessive tx with dominant rx
// - receiver keeps mirroring bus during clamped and timeout faults
// - falling transmit edge with driver active starts dominant timeout
// - timeout expiry without rising edge disables driver, bus recessive
// - next transmit rising edge re-enables driver after timeout
// - thermal shutdown turns driver off, receive path stays working
// - thermal fault clears when cool, returns on over-temperature
// - active thermal fault is shown on the fault output
// - any supply undervoltage removes bus load
// - battery undervoltage puts the transceiver in its off state
// - transceiver supply low: stay in mode until the filter expires, receive output held high
// - logic supply low gives standby; long transceiver or logic supply undervoltage gives sleep
// - resume operation about 200 us after supplies recover
// - floating pins default to recessive transmit and low-power mode
// - transmit timeout flag set, reported on normal-to-silent change
module cfm_fault_monitor #(
    parameter int TXTO_CYC = cfm_pkg::TX_TIMEOUT_CYC,
    parameter int BUSDOM_CYC = cfm_pkg::BUS_DOM_CYC_DEF,
    parameter int UVF_CYC = cfm_pkg::UV_FILTER_CYC_DEF
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire cfm_pkg::cfm_axi_req_t axi_req,
    output cfm_pkg::cfm_axi_rsp_t axi_rsp,
    // controller side
    input wire logic tx_data,
    output logic rx_data_q,
    output logic fault_indicator_n_q,
    // bus side, low means dominant
    input wire logic bus_rx,
    output logic driver_enable_q,
    output logic bus_load_off_q,
    output logic can_off_q,
    output logic autonomous_active_q,
    // supervision inputs
    input wire logic over_temp,
    input wire logic uv_battery,
    input wire logic uv_transceiver_supply,
    input wire logic uv_logic_supply
);

    localparam int TW = $clog2(TXTO_CYC + 1);
    localparam int BW = $clog2(BUSDOM_CYC + 1);
    localparam int UW = $clog2(UVF_CYC + 1);
    localparam int RW = $clog2(cfm_pkg::RESUME_CYC + 1);
    localparam logic [TW-1:0] TXTO_MAX = TW'(TXTO_CYC);
    localparam logic [BW-1:0] BUSDOM_MAX = BW'(BUSDOM_CYC);
    localparam logic [UW-1:0] UVF_MAX = UW'(UVF_CYC);
    localparam logic [RW-1:0] RESUME_MAX = RW'(cfm_pkg::RESUME_CYC);

    if (TXTO_CYC < 1 || BUSDOM_CYC < 1 || UVF_CYC < 1) begin : g_chk
        $error("cfm_fault_monitor: counts must be at least one");
    end

    function automatic logic mode_legal(input logic [2:0] code);
        mode_legal = code <= 3'(cfm_pkg::CFM_SLEEP);
    endfunction

    // state
    cfm_pkg::cfm_mode_t mode_q, mode_d;
    logic bus_dom_q, clamped_q, tx_to_q, tsd_q, report_q;
    logic tx_prev_q, tx_run_q;
    logic [TW-1:0] tx_cnt_q;
    logic [BW-1:0] bus_cnt_q;
    logic [UW-1:0] uv_cnt_q;
    logic [RW-1:0] resume_cnt_q;

    // bus slave state
    logic aw_got_q, w_got_q, ar_busy_q;
    logic [cfm_pkg::ADDR_W-1:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;

    // bus decode
    wire aw_hs = axi_req.awvalid & awready_q;
    wire w_hs = axi_req.wvalid & wready_q;
    wire ar_hs = axi_req.arvalid & arready_q;
    wire do_write = aw_got_q & w_got_q & ~bvalid_q;
    wire wr_ctrl = do_write & (waddr_q == cfm_pkg::ADDR_CTRL);
    wire wr_hit = wr_ctrl | (waddr_q == cfm_pkg::ADDR_STATUS);
    wire [2:0] wr_mode = wdata_q[cfm_pkg::CTRL_MODE_LSB +: cfm_pkg::MODE_W];
    wire mode_wr = wr_ctrl & wstrb_q[0] & mode_legal(wr_mode);
    wire rd_ctrl = axi_req.araddr == cfm_pkg::ADDR_CTRL;
    wire rd_stat = axi_req.araddr == cfm_pkg::ADDR_STATUS;

    // supply supervision
    wire uv_any = uv_battery | uv_transceiver_supply | uv_logic_supply;
    wire uv_filt = uv_transceiver_supply | uv_logic_supply;
    wire uv_long = uv_filt & (uv_cnt_q == UVF_MAX);
    wire resumed = ~uv_any & (resume_cnt_q == RESUME_MAX);

    // mode selection
    always_comb begin
        mode_d = mode_q;
        if (uv_long) begin
            mode_d = cfm_pkg::CFM_SLEEP;
        end else if (uv_logic_supply) begin
            mode_d = cfm_pkg::CFM_STANDBY;
        end else if (mode_wr) begin
            mode_d = cfm_pkg::cfm_mode_t'(wr_mode);
        end
    end

    wire mode_chg = mode_d != mode_q;
    wire n2s = (mode_q == cfm_pkg::CFM_NORMAL) &
        (mode_d == cfm_pkg::CFM_SILENT);
    wire enter_normal = mode_chg & (mode_d == cfm_pkg::CFM_NORMAL);
    wire clear_local = mode_chg & ~n2s;
    wire clear_busdom = mode_chg & (mode_d != cfm_pkg::CFM_SILENT);

    // edges and receive path
    wire tx_fall = tx_prev_q & ~tx_data;
    wire tx_rise = ~tx_prev_q & tx_data;
    wire rx_d = uv_transceiver_supply | bus_rx;
    wire rx_rise = ~rx_data_q & rx_d;

    // flags
    wire bus_dom_set = ~bus_rx & (bus_cnt_q == BUSDOM_MAX);
    wire bus_dom_d = bus_dom_set |
        (bus_dom_q & ~rx_rise & ~clear_busdom);
    wire tx_to_set = tx_run_q & ~tx_data & (tx_cnt_q == TXTO_MAX);
    wire tx_to_d = tx_to_set | (tx_to_q & ~tx_rise & ~clear_local);
    wire clamp_set = enter_normal & ~tx_data;
    wire clamp_clr = enter_normal | clear_local |
        (tx_data & ~bus_rx & ~tx_to_q & ~tsd_q);
    wire clamped_d = clamp_set | (clamped_q & ~clamp_clr);
    wire local_any = bus_dom_d | clamped_d | tx_to_d;
    wire report_d = n2s ? local_any : (report_q & ~mode_chg);
    wire drv_d = (mode_d == cfm_pkg::CFM_NORMAL) & ~clamped_d & ~tx_to_d &
        ~over_temp & resumed;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= cfm_pkg::MODE_RESET;
            bus_dom_q <= 1'b0;
            clamped_q <= 1'b0;
            tx_to_q <= 1'b0;
            tsd_q <= 1'b0;
            report_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            bus_dom_q <= bus_dom_d;
            clamped_q <= clamped_d;
            tx_to_q <= tx_to_d;
            tsd_q <= over_temp;
            report_q <= report_d;
        end
    end

    // counters of the reference clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_prev_q <= 1'b1;
            tx_run_q <= 1'b0;
            tx_cnt_q <= '0;
            bus_cnt_q <= '0;
            uv_cnt_q <= '0;
            resume_cnt_q <= '0;
        end else begin
            tx_prev_q <= tx_data;
            if (tx_fall && driver_enable_q) begin
                tx_run_q <= 1'b1;
                tx_cnt_q <= '0;
            end else if (tx_data || tx_to_set) begin
                tx_run_q <= 1'b0;
                tx_cnt_q <= '0;
            end else if (tx_run_q) begin
                tx_cnt_q <= tx_cnt_q + 1'b1;
            end
            if (bus_rx) begin
                bus_cnt_q <= '0;
            end else if (bus_cnt_q != BUSDOM_MAX) begin
                bus_cnt_q <= bus_cnt_q + 1'b1;
            end
            if (!uv_filt) begin
                uv_cnt_q <= '0;
            end else if (!uv_long) begin
                uv_cnt_q <= uv_cnt_q + 1'b1;
            end
            if (uv_any) begin
                resume_cnt_q <= '0;
            end else if (!resumed) begin
                resume_cnt_q <= resume_cnt_q + 1'b1;
            end
        end
    end

    // pin outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_data_q <= 1'b1;
            fault_indicator_n_q <= 1'b1;
            driver_enable_q <= 1'b0;
            bus_load_off_q <= 1'b0;
            can_off_q <= 1'b0;
            autonomous_active_q <= 1'b0;
        end else begin
            rx_data_q <= rx_d;
            fault_indicator_n_q <= ~(report_d | over_temp);
            driver_enable_q <= drv_d;
            bus_load_off_q <= uv_any;
            can_off_q <= uv_battery;
            autonomous_active_q <= uv_transceiver_supply;
        end
    end

    // status word
    logic [31:0] status_w;
    always_comb begin
        status_w = '0;
        status_w[cfm_pkg::ST_BUS_DOM] = bus_dom_q;
        status_w[cfm_pkg::ST_CLAMPED] = clamped_q;
        status_w[cfm_pkg::ST_TX_TIMEOUT] = tx_to_q;
        status_w[cfm_pkg::ST_THERMAL] = tsd_q;
        status_w[cfm_pkg::ST_DRV_EN] = driver_enable_q;
        status_w[cfm_pkg::ST_FAULT_N] = fault_indicator_n_q;
        status_w[cfm_pkg::ST_CAN_OFF] = can_off_q;
        status_w[cfm_pkg::ST_LOAD_OFF] = bus_load_off_q;
        status_w[cfm_pkg::ST_MODE_LSB +: cfm_pkg::MODE_W] = mode_q;
    end
    wire [31:0] ctrl_w = {29'h0, mode_q};

    // write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= cfm_pkg::RESP_OKAY;
        end else begin
            if (aw_hs) begin
                aw_got_q <= 1'b1;
                awready_q <= 1'b0;
                waddr_q <= axi_req.awaddr;
            end
            if (w_hs) begin
                w_got_q <= 1'b1;
                wready_q <= 1'b0;
                wdata_q <= axi_req.wdata;
                wstrb_q <= axi_req.wstrb;
            end
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? cfm_pkg::RESP_OKAY : cfm_pkg::RESP_SLVERR;
            end
            if (bvalid_q && axi_req.bready) begin
                bvalid_q <= 1'b0;
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_busy_q <= 1'b0;
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= cfm_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            ar_busy_q <= 1'b1;
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_ctrl ? ctrl_w : (rd_stat ? status_w : 32'h0);
            rresp_q <= (rd_ctrl | rd_stat) ? cfm_pkg::RESP_OKAY :
                cfm_pkg::RESP_SLVERR;
        end else if (rvalid_q && axi_req.rready) begin
            ar_busy_q <= 1'b0;
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    assign axi_rsp = '{awready: awready_q, wready: wready_q,
        bvalid: bvalid_q, bresp: bresp_q, arready: arready_q,
        rvalid: rvalid_q, rdata: rdata_q, rresp: rresp_q};

    // checks
    a_busdom_set_flag: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (!bus_rx && bus_cnt_q == BUSDOM_MAX) |=> bus_dom_q)
        else $error("bus stuck flag not set");
    a_busdom_rx_clear: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (rx_rise && bus_rx) |=> !bus_dom_q)
        else $error("bus stuck flag not cleared");
    a_busdom_mode_clear: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (clear_busdom && !bus_dom_set) |=> !bus_dom_q)
        else $error("bus stuck flag kept over mode change");
    a_report_n2s_flag: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (n2s && local_any) |=> !fault_indicator_n_q)
        else $error("fault not reported on silent entry");
    a_report_holds_low: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (report_q && !mode_chg) |=> !fault_indicator_n_q)
        else $error("fault report dropped within silent mode");
    a_local_mode_clear: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (clear_local && !clamp_set && !tx_to_set && !over_temp) |=>
        (!tx_to_q && !clamped_q && fault_indicator_n_q))
        else $error("local faults kept over mode change");
    a_timeout_arms: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (tx_fall && driver_enable_q) |=> (tx_run_q && tx_cnt_q == '0))
        else $error("dominant timeout not started");
    a_timeout_drv_off: assert property (@(posedge aclk)
        disable iff (!aresetn)
        tx_to_set |=> (tx_to_q && !driver_enable_q))
        else $error("driver active after timeout");
    a_timeout_release: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (tx_to_q && tx_rise && !tx_to_set) |=> !tx_to_q)
        else $error("timeout not released on rising tx");
    a_thermal_drv_off: assert property (@(posedge aclk)
        disable iff (!aresetn)
        over_temp |=> (!driver_enable_q && !fault_indicator_n_q))
        else $error("thermal fault not acted on");
    a_rx_mirror_bus: assert property (@(posedge aclk)
        disable iff (!aresetn)
        !uv_transceiver_supply |=> rx_data_q == $past(bus_rx))
        else $error("receive output does not follow bus");
    a_uv_protect_off: assert property (@(posedge aclk)
        disable iff (!aresetn)
        uv_battery |=> (bus_load_off_q && can_off_q && !driver_enable_q))
        else $error("battery undervoltage not protected");
    a_uvcc_rx_high: assert property (@(posedge aclk)
        disable iff (!aresetn)
        uv_transceiver_supply |=> (rx_data_q && autonomous_active_q))
        else $error("receive output not held high");
    a_uvio_standby: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (uv_logic_supply && !uv_long) |=>
        (mode_q == cfm_pkg::CFM_STANDBY || mode_q == cfm_pkg::CFM_SLEEP))
        else $error("logic undervoltage not in standby");
    a_clamp_blocks_drv: assert property (@(posedge aclk)
        disable iff (!aresetn)
        clamp_set |=> (clamped_q && !driver_enable_q))
        else $error("clamped transmit not blocking driver");
    a_clamp_rx_clear: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (clamped_q && tx_data && !bus_rx && !tx_to_q && !tsd_q) |=>
        !clamped_q)
        else $error("clamped flag not released");
    a_resume_drv_off: assert property (@(posedge aclk)
        disable iff (!aresetn)
        !resumed |=> !driver_enable_q)
        else $error("driver active before supplies settled");

endmodule

// ---- tb/cfm_ctrl_model.sv ----
`timescale 1ns/10ps
// controller on the transmit pin
module cfm_ctrl_model (
    // clock
    input wire logic aclk,
    // commands from the bench
    input wire logic active,
    input wire logic hold_low,
    // transmit pin
    output logic tx_data
);
    logic [3:0] ph_q;
    always_ff @(posedge aclk) begin
        ph_q <= active ? ph_q + 4'h1 : 4'h0;
    end
    // runs of eight cycles, far inside the timeout
    assign tx_data = hold_low ? 1'b0 : (active ? ph_q[3] : 1'b1);
endmodule

// ---- tb/cfm_fault_monitor_tb.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    bad_count++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module cfm_fault_monitor_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    cfm_pkg::cfm_axi_req_t req = '0;
    cfm_pkg::cfm_axi_rsp_t rsp;
    logic active = 1'b0, hold_low = 1'b0, bus_rx = 1'b1, over_temp = 1'b0;
    logic uv_bat = 1'b0, uv_xcvr = 1'b0, uv_log = 1'b0;
    logic tx_data, rx, fault_n, drv, load_off, can_off, auto_act;
    int bad_count = 0, n_compared = 0, cyc = 0;
    logic [31:0] rd;
    logic [1:0] rs;
    localparam logic [3:0] CTL = cfm_pkg::ADDR_CTRL;
    localparam logic [3:0] STA = cfm_pkg::ADDR_STATUS;
    always #25 aclk = ~aclk;
    cfm_ctrl_model cfm_ctrl_model_i (.aclk(aclk), .active(active),
        .hold_low(hold_low), .tx_data(tx_data));
    cfm_fault_monitor #(.TXTO_CYC(20), .BUSDOM_CYC(10), .UVF_CYC(10))
    cfm_fault_monitor_i (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
        .axi_rsp(rsp), .tx_data(tx_data), .rx_data_q(rx),
        .fault_indicator_n_q(fault_n), .bus_rx(bus_rx),
        .driver_enable_q(drv), .bus_load_off_q(load_off),
        .can_off_q(can_off), .autonomous_active_q(auto_act),
        .over_temp(over_temp), .uv_battery(uv_bat),
        .uv_transceiver_supply(uv_xcvr), .uv_logic_supply(uv_log));
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 12000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        while (1) begin
            @(posedge aclk);
            if (req.awvalid === 1'b1 && rsp.awready === 1'b1) begin
                req.awvalid <= 1'b0;
            end
            if (req.wvalid === 1'b1 && rsp.wready === 1'b1) begin
                req.wvalid <= 1'b0;
            end
            if (rsp.bvalid === 1'b1) begin
                rs = rsp.bresp;
                req.bready <= 1'b0;
                break;
            end
        end
        #1;
    endtask
    task automatic rdr(input logic [3:0] a);
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        while (1) begin
            @(posedge aclk);
            if (req.arvalid === 1'b1 && rsp.arready === 1'b1) begin
                req.arvalid <= 1'b0;
            end
            if (rsp.rvalid === 1'b1) begin
                rd = rsp.rdata;
                rs = rsp.rresp;
                req.rready <= 1'b0;
                break;
            end
        end
        #1;
    endtask
    task automatic t_regs;
        tick(1);
        rdr(STA);
        `CHK("status", 32'h0000_0420, rd)
        rdr(4'h8);
        `CHK("rresp", cfm_pkg::RESP_SLVERR, rs)
        wr(4'hc, 32'h0);
        `CHK("bresp", cfm_pkg::RESP_SLVERR, rs)
        for (int i = 0; i < 5; i++) begin
            wr(CTL, i);
            rdr(CTL);
            `CHK("mode", 3'(i), rd[2:0])
        end
        wr(CTL, 32'h5);
        rdr(CTL);
        `CHK("mode", 3'h4, rd[2:0])
        wr(CTL, 32'h0);
        tick(2);
        `CHK("drv", 1'b0, drv)
        tick(4000);
        `CHK("drv", 1'b1, drv)
        @(posedge aclk) active <= 1'b1;
        tick(60);
        `CHK("drv", 1'b1, drv)
        @(posedge aclk) active <= 1'b0;
        $display("test regs done");
    endtask
    task automatic t_timeout;
        @(posedge aclk) hold_low <= 1'b1;
        tick(15);
        `CHK("drv", 1'b1, drv)
        tick(10);
        `CHK("drv", 1'b0, drv)
        @(posedge aclk) bus_rx <= 1'b0;
        tick(2);
        `CHK("rx", 1'b0, rx)
        @(posedge aclk) bus_rx <= 1'b1;
        tick(2);
        `CHK("rx", 1'b1, rx)
        rdr(STA);
        `CHK("tx_to", 1'b1, rd[cfm_pkg::ST_TX_TIMEOUT])
        @(posedge aclk) hold_low <= 1'b0;
        tick(3);
        `CHK("drv", 1'b1, drv)
        @(posedge aclk) hold_low <= 1'b1;
        tick(25);
        wr(CTL, 32'h1);
        tick(2);
        `CHK("fault_n", 1'b0, fault_n)
        @(posedge aclk) hold_low <= 1'b0;
        wr(CTL, 32'h0);
        tick(2);
        `CHK("fault_n", 1'b1, fault_n)
        $display("test timeout done");
    endtask
    task automatic t_clamp;
        wr(CTL, 32'h2);
        @(posedge aclk) hold_low <= 1'b1;
        wr(CTL, 32'h0);
        tick(3);
        `CHK("drv", 1'b0, drv)
        rdr(STA);
        `CHK("clamp", 1'b1, rd[cfm_pkg::ST_CLAMPED])
        @(posedge aclk) bus_rx <= 1'b0;
        hold_low <= 1'b0;
        tick(3);
        `CHK("drv", 1'b1, drv)
        @(posedge aclk) bus_rx <= 1'b1;
        $display("test clamp done");
    endtask
    task automatic t_stuck;
        @(posedge aclk) bus_rx <= 1'b0;
        tick(15);
        rdr(STA);
        `CHK("stuck", 1'b1, rd[cfm_pkg::ST_BUS_DOM])
        wr(CTL, 32'h1);
        tick(2);
        `CHK("fault_n", 1'b0, fault_n)
        @(posedge aclk) bus_rx <= 1'b1;
        tick(3);
        rdr(STA);
        `CHK("stuck", 1'b0, rd[cfm_pkg::ST_BUS_DOM])
        wr(CTL, 32'h0);
        tick(2);
        `CHK("fault_n", 1'b1, fault_n)
        $display("test stuck done");
    endtask
    task automatic t_supply;
        @(posedge aclk) over_temp <= 1'b1;
        bus_rx <= 1'b0;
        tick(3);
        `CHK("drv", 1'b0, drv)
        `CHK("rx", 1'b0, rx)
        `CHK("fault_n", 1'b0, fault_n)
        @(posedge aclk) over_temp <= 1'b0;
        bus_rx <= 1'b1;
        tick(3);
        `CHK("fault_n", 1'b1, fault_n)
        @(posedge aclk) over_temp <= 1'b1;
        tick(3);
        `CHK("fault_n", 1'b0, fault_n)
        @(posedge aclk) over_temp <= 1'b0;
        uv_bat <= 1'b1;
        tick(3);
        `CHK("can_off", 1'b1, can_off)
        `CHK("load_off", 1'b1, load_off)
        @(posedge aclk) uv_bat <= 1'b0;
        uv_xcvr <= 1'b1;
        bus_rx <= 1'b0;
        tick(3);
        `CHK("rx", 1'b1, rx)
        `CHK("auto", 1'b1, auto_act)
        rdr(CTL);
        `CHK("mode", 3'h0, rd[2:0])
        tick(12);
        rdr(CTL);
        `CHK("mode", 3'h4, rd[2:0])
        @(posedge aclk) uv_xcvr <= 1'b0;
        bus_rx <= 1'b1;
        // fresh logic undervoltage, filter restarts
        @(posedge aclk) uv_log <= 1'b1;
        tick(3);
        rdr(CTL);
        `CHK("mode", 3'h2, rd[2:0])
        @(posedge aclk) uv_log <= 1'b0;
        $display("test supply done");
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_timeout();
        t_clamp();
        t_stuck();
        t_supply();
        give_verdict();
    end
endmodule
